/* rtl/ocdac_pkg.sv */
// package for the octal dac serial command decoder: constants, codes, state types
// assumes a single 50 MHz ref_clk domain; bus pins and strobes arrive asynchronously
package ocdac_pkg;

  // ==========================================================================
  // sizes and codes
  localparam int unsigned CODE_W = 16;
  localparam int unsigned NUM_CH = 8;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [2:0] LAST_DATA_BYTE = 3'h3;
  localparam logic [3:0] CMD_WRITE_IN = 4'h0;
  localparam logic [3:0] CMD_UPDATE = 4'h1;
  localparam logic [3:0] CMD_WRITE_UPD_ALL = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPD = 4'h3;
  localparam logic [3:0] CMD_PD_CHAN = 4'h4;
  localparam logic [3:0] CMD_PD_CHIP = 4'h5;
  localparam logic [3:0] CMD_REF_INT = 4'h6;
  localparam logic [3:0] CMD_REF_EXT = 4'h7;
  localparam logic [3:0] CMD_NOP = 4'hF;
  localparam logic [3:0] SEL_ALL = 4'hF;
  localparam logic [6:0] GLOBAL_ADDR = 7'h73;
  localparam logic [2:0] ADDR_HI_BASE = 3'h1;
  localparam logic [CODE_W-1:0] ZERO_SCALE = 16'h0000;
  localparam logic [CODE_W-1:0] MID_SCALE = 16'h8000;
  localparam logic [1:0] INIT_WAIT = 2'h3;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {OCDAC_PIN_LOW, OCDAC_PIN_FLOAT, OCDAC_PIN_HIGH} ocdac_pin_t;
  typedef enum logic [1:0] {RX_IDLE, RX_BITS, RX_ACK, RX_SKIP} ocdac_rx_st_t;

  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] sel;
    logic [CODE_W-1:0] code;
  } ocdac_word_t;

  typedef struct packed {
    logic scl_m, scl_s, scl_p;
    logic sda_m, sda_s, sda_p;
    ocdac_rx_st_t st;
    logic [3:0] bitcnt;
    logic [2:0] bytecnt;
    logic [7:0] shift;
    ocdac_word_t word;
    logic oe;
    logic done;
  } ocdac_rx_t;

  typedef struct packed {
    logic [1:0] init_cnt;
    logic strobe_m, strobe_s, strobe_p;
    logic strap_m, strap_s;
    logic [5:0] ca_m, ca_s;
    logic armed;
    logic ref_int;
    logic ref_up;
    logic [NUM_CH-1:0] pd;
    logic [NUM_CH-1:0][CODE_W-1:0] in_code;
    logic [NUM_CH-1:0][CODE_W-1:0] out_code;
  } ocdac_top_t;

  // ==========================================================================
  // decoders
  // channel select to one-hot mask, all ones for SEL_ALL; reserved selects hit nothing
  function automatic logic [NUM_CH-1:0] ocdac_chan_mask(input logic [3:0] sel);
    logic [NUM_CH-1:0] m;
    m = '0;
    if (sel == SEL_ALL) m = '1;
    else if (sel[3] == 1'b0) m[sel[2:0]] = 1'b1;
    return m;
  endfunction

  // three tri-level pins to slave address: index n gives {n/4+1, 00, n%4}
  function automatic logic [6:0] ocdac_addr(input logic [5:0] ca);
    logic [4:0] n;
    n = 5'(ca[5:4]) * 5'h09 + 5'(ca[3:2]) * 5'h03 + 5'(ca[1:0]);
    return {n[4:2] + ADDR_HI_BASE, 2'h0, n[1:0]};
  endfunction

endpackage

/* rtl/ocdac_rx.sv */
// two-wire write-only receiver: start/stop detect, byte shift, ack, 24-bit word
// assumes scl and sda are raw pin levels; ref_clk far faster than the bus clock
`timescale 1ns/10ps
module ocdac_rx import ocdac_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [6:0] dev_addr,
  output logic sda_o,
  output logic sda_oe,
  output logic word_valid,
  output ocdac_word_t word
);

  // ==========================================================================
  // state
  ocdac_rx_t q_r, q_nxt;
  logic rise, fall, start, stop, hit;

  // edges use the second and third stage only; the first stage feeds nothing else
  assign rise = q_r.scl_s & ~q_r.scl_p;
  assign fall = ~q_r.scl_s & q_r.scl_p;
  assign start = q_r.scl_s & q_r.scl_p & q_r.sda_p & ~q_r.sda_s;
  assign stop = q_r.scl_s & q_r.scl_p & ~q_r.sda_p & q_r.sda_s;
  assign hit = (q_r.shift[7:1] == dev_addr) || (q_r.shift[7:1] == GLOBAL_ADDR);

  // ==========================================================================
  // receive sequence
  always_comb begin
    q_nxt = q_r;
    q_nxt.scl_m = scl_i;
    q_nxt.scl_s = q_r.scl_m;
    q_nxt.scl_p = q_r.scl_s;
    q_nxt.sda_m = sda_i;
    q_nxt.sda_s = q_r.sda_m;
    q_nxt.sda_p = q_r.sda_s;
    q_nxt.done = 1'b0;
    if (start) begin
      q_nxt.st = RX_BITS;
      q_nxt.bitcnt = '0;
      q_nxt.bytecnt = '0;
      q_nxt.oe = 1'b0;
    end else if (stop) begin
      q_nxt.st = RX_IDLE;
      q_nxt.oe = 1'b0;
    end else begin
      case (q_r.st)
        RX_BITS: begin
          if (rise && q_r.bitcnt < BYTE_BITS) begin
            q_nxt.shift = {q_r.shift[6:0], q_r.sda_s};
            q_nxt.bitcnt = q_r.bitcnt + 4'h1;
          end else if (fall && q_r.bitcnt == BYTE_BITS) begin
            if (q_r.bytecnt == 3'h0) begin
              // a read bit set means no answer at all
              if (hit && !q_r.shift[0]) begin
                q_nxt.st = RX_ACK;
                q_nxt.oe = 1'b1;
              end else begin
                q_nxt.st = RX_SKIP;
              end
            end else if (q_r.bytecnt <= LAST_DATA_BYTE) begin
              q_nxt.st = RX_ACK;
              q_nxt.oe = 1'b1;
              q_nxt.word = {q_r.word[15:0], q_r.shift};
            end else begin
              q_nxt.st = RX_SKIP;
            end
          end
        end
        RX_ACK: begin
          // ack slot ends at the falling edge of the ninth clock
          if (fall) begin
            q_nxt.oe = 1'b0;
            q_nxt.st = RX_BITS;
            q_nxt.bitcnt = '0;
            q_nxt.bytecnt = q_r.bytecnt + 3'h1;
            q_nxt.done = (q_r.bytecnt == LAST_DATA_BYTE);
          end
        end
        default: ;
      endcase
    end
  end

  // state register: constants only under reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '{st: RX_IDLE, scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
               sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1, default: '0};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign sda_o = 1'b0; // open drain: only the enable ever changes
  assign sda_oe = q_r.oe;
  assign word_valid = q_r.done;
  assign word = q_r.word;

  // ==========================================================================
  // checks
  a_shift_released: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (q_r.st != RX_ACK) |-> !q_r.oe) else $error("data line driven outside ack slot");
  a_extra_nack: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (q_r.st == RX_ACK) |-> (q_r.bytecnt <= LAST_DATA_BYTE)) else $error("extra byte acked");

endmodule

/* rtl/ocdac_top.sv */
// command decoder top: serial receiver, channel registers, power and reference state
// assumes address pins come pre-resolved; strobes and straps are asynchronous pins
`timescale 1ns/10ps
module ocdac_top import ocdac_pkg::*; #(
  parameter int unsigned RES = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic load_strobe_n,
  input wire logic reset_scale_select,
  input wire ocdac_pin_t addr_pin_0,
  input wire ocdac_pin_t addr_pin_1,
  input wire ocdac_pin_t addr_pin_2,
  output logic [NUM_CH-1:0][RES-1:0] dac_code,
  output logic [NUM_CH-1:0] chan_powered_down,
  output logic ref_internal,
  output logic ref_powered
);

  // ==========================================================================
  // elaboration check
  generate
    if (!(RES == 16 || RES == 12)) begin : g_bad_res
      $error("resolution must be 16 or 12");
    end
  endgenerate

  // low bits beyond the resolution are dropped so both variants share storage
  localparam logic [CODE_W-1:0] CODE_MASK = ~((CODE_W'(1) << (CODE_W - RES)) - CODE_W'(1));

  // ==========================================================================
  // receiver
  ocdac_top_t q_r, q_nxt;
  logic rx_valid;
  ocdac_word_t rx_word;
  logic [6:0] dev_addr;

  assign dev_addr = ocdac_addr(q_r.ca_s);

  ocdac_rx u_rx (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .dev_addr(dev_addr),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .word_valid(rx_valid),
    .word(rx_word)
  );

  // ==========================================================================
  // command execution
  logic [NUM_CH-1:0] mask;
  logic [CODE_W-1:0] code;
  logic strobe_low, strobe_fall, init_load;

  assign mask = ocdac_chan_mask(rx_word.sel);
  assign code = rx_word.code & CODE_MASK;
  assign strobe_low = ~q_r.strobe_s;
  assign strobe_fall = q_r.strobe_p & ~q_r.strobe_s;
  assign init_load = (q_r.init_cnt == 2'h1);

  always_comb begin
    q_nxt = q_r;
    // two-stage synchronisers for every pin input
    q_nxt.strobe_m = load_strobe_n;
    q_nxt.strobe_s = q_r.strobe_m;
    q_nxt.strobe_p = q_r.strobe_s;
    q_nxt.strap_m = reset_scale_select;
    q_nxt.strap_s = q_r.strap_m;
    q_nxt.ca_m = {addr_pin_2, addr_pin_1, addr_pin_0};
    q_nxt.ca_s = q_r.ca_m;
    if (q_r.init_cnt != 2'h0) begin
      q_nxt.init_cnt = q_r.init_cnt - 2'h1;
      // strap is caught once its synchroniser has settled
      if (init_load) begin
        for (int i = 0; i < NUM_CH; i++) begin
          q_nxt.out_code[i] = q_r.strap_s ? MID_SCALE : ZERO_SCALE;
          q_nxt.in_code[i] = q_r.strap_s ? MID_SCALE : ZERO_SCALE;
        end
      end
    end else begin
      if (rx_valid) begin
        q_nxt.armed = 1'b1;
        case (rx_word.cmd)
          CMD_WRITE_IN: begin
            for (int i = 0; i < NUM_CH; i++) begin
              if (mask[i]) q_nxt.in_code[i] = code;
            end
          end
          CMD_UPDATE: begin
            for (int i = 0; i < NUM_CH; i++) begin
              if (mask[i]) begin
                q_nxt.out_code[i] = q_r.in_code[i];
                q_nxt.pd[i] = 1'b0;
              end
            end
          end
          CMD_WRITE_UPD_ALL: begin
            for (int i = 0; i < NUM_CH; i++) begin
              q_nxt.in_code[i] = mask[i] ? code : q_r.in_code[i];
              q_nxt.out_code[i] = q_nxt.in_code[i];
            end
            q_nxt.pd = '0;
          end
          CMD_WRITE_UPD: begin
            for (int i = 0; i < NUM_CH; i++) begin
              if (mask[i]) begin
                q_nxt.in_code[i] = code;
                q_nxt.out_code[i] = code;
                q_nxt.pd[i] = 1'b0;
              end
            end
          end
          CMD_PD_CHAN: begin
            // only the power flags move; codes stay put
            if (!strobe_low) q_nxt.pd = q_r.pd | mask;
          end
          CMD_PD_CHIP: begin
            if (!strobe_low) begin
              q_nxt.pd = '1;
              q_nxt.ref_up = 1'b0;
            end
          end
          CMD_REF_INT: begin
            q_nxt.ref_int = 1'b1;
            q_nxt.ref_up = 1'b1;
          end
          CMD_REF_EXT: begin
            // selects the external reference and powers the internal one down; chip power-down also clears ref_up
            q_nxt.ref_int = 1'b0;
            q_nxt.ref_up = 1'b0;
          end
          CMD_NOP: ;
          default: ;
        endcase
      end
      // strobe edge after a complete write; applied after the command so nothing is lost
      if (strobe_fall && (q_r.armed || rx_valid)) begin
        q_nxt.out_code = q_nxt.in_code;
      end
    end
  end

  // state register: internal reference up and all channels up after reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '{init_cnt: INIT_WAIT, strobe_m: 1'b1, strobe_s: 1'b1, strobe_p: 1'b1,
               ref_int: 1'b1, ref_up: 1'b1, default: '0};
    end else begin
      q_r <= q_nxt;
    end
  end

  // ==========================================================================
  // outputs
  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_out
      assign dac_code[g] = q_r.out_code[g][CODE_W-1 -: RES];
    end
  endgenerate
  assign chan_powered_down = q_r.pd;
  assign ref_internal = q_r.ref_int;
  assign ref_powered = q_r.ref_up;

  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic run;
  assign run = (q_r.init_cnt == 2'h0);

  a_write_input: assert property (
    run && rx_valid && rx_word.cmd == CMD_WRITE_IN && !rx_word.sel[3] && !strobe_fall |=>
      q_r.in_code[$past(rx_word.sel[2:0])] == $past(code) && $stable(q_r.out_code))
    else $error("write to input register wrong");
  a_update_chan: assert property (
    run && rx_valid && rx_word.cmd == CMD_UPDATE && !rx_word.sel[3] |=>
      q_r.out_code[$past(rx_word.sel[2:0])] == $past(q_r.in_code[rx_word.sel[2:0]])
      && !q_r.pd[$past(rx_word.sel[2:0])])
    else $error("channel update wrong");
  a_update_all: assert property (
    run && rx_valid && rx_word.cmd == CMD_WRITE_UPD_ALL |=>
      q_r.out_code == q_r.in_code && q_r.pd == '0)
    else $error("update all wrong");
  a_write_update: assert property (
    run && rx_valid && rx_word.cmd == CMD_WRITE_UPD && !rx_word.sel[3] |=>
      q_r.out_code[$past(rx_word.sel[2:0])] == $past(code))
    else $error("write and update wrong");
  a_pd_keeps_codes: assert property (
    run && rx_valid && (rx_word.cmd == CMD_PD_CHAN || rx_word.cmd == CMD_PD_CHIP)
      && !strobe_fall |=> $stable(q_r.in_code) && $stable(q_r.out_code))
    else $error("power-down disturbed codes");
  a_pd_blocked: assert property (
    run && rx_valid && strobe_low && (rx_word.cmd == CMD_PD_CHAN || rx_word.cmd == CMD_PD_CHIP)
      |=> $stable(q_r.pd) && $stable(q_r.ref_up))
    else $error("power-down taken while strobe low");
  a_chip_down: assert property (
    run && rx_valid && rx_word.cmd == CMD_PD_CHIP && !strobe_low |=> q_r.pd == '1 && !q_r.ref_up)
    else $error("chip power-down wrong");
  a_ref_select: assert property (
    run && rx_valid && rx_word.cmd[3:1] == CMD_REF_INT[3:1] |=>
      q_r.ref_int == $past(rx_word.cmd[0] == 1'b0) && q_r.ref_up == q_r.ref_int)
    else $error("reference select wrong");
  a_strobe_copy: assert property (
    run && strobe_fall && q_r.armed && !rx_valid |=> q_r.out_code == q_r.in_code)
    else $error("strobe did not update outputs");
  a_strobe_unarmed: assert property (
    run && !q_r.armed && !rx_valid |=> $stable(q_r.out_code))
    else $error("outputs changed without a complete write");
  a_reset_scale: assert property (
    init_load |=> q_r.out_code[0] == ($past(q_r.strap_s) ? MID_SCALE : ZERO_SCALE))
    else $error("reset scale wrong");

  c_write_update: cover property (run && rx_valid && rx_word.cmd == CMD_WRITE_UPD);
  c_strobe_copy: cover property (run && strobe_fall && q_r.armed);
  c_pd_blocked: cover property (run && rx_valid && strobe_low && rx_word.cmd == CMD_PD_CHAN);
  c_ref_ext: cover property (run && rx_valid && rx_word.cmd == CMD_REF_EXT);

endmodule

/* testbench/ocdac_host_model.sv */
// two-wire bus master model that writes command frames to the decoder
// assumes an open-drain data wire resolved by the bench with a pull-up
`timescale 1ns/10ps
module ocdac_host_model (
  input wire logic ref_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  // ==========================================================================
  // idle bus: clock parked high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // ==========================================================================
  // one frame: start, nb bytes msb first from the top of w, stop
  // low phase 5 cycles, high 3: data moves 2 cycles after the fall so the
  // receiver's synchronised clock is already low when data changes
  task automatic frame(input logic [39:0] w, input int nb, output logic [4:0] nack);
    nack = '0;
    sda_low <= 1'b1;
    tk(4);
    for (int b = 0; b < nb; b++) begin
      for (int i = 39 - 8 * b; i > 31 - 8 * b; i--) begin
        scl <= 1'b0;
        tk(2);
        sda_low <= ~w[i];
        tk(3);
        scl <= 1'b1;
        tk(3);
      end
      // ninth clock: release the wire and look for the pull-down mid-high
      scl <= 1'b0;
      tk(2);
      sda_low <= 1'b0;
      tk(3);
      scl <= 1'b1;
      tk(1);
      nack[4 - b] = sda_line;
      tk(2);
    end
    scl <= 1'b0;
    tk(2);
    sda_low <= 1'b1;
    tk(3);
    scl <= 1'b1;
    tk(3);
    sda_low <= 1'b0;
    tk(4);
  endtask
endmodule

/* testbench/octal_dac_serial_command_decoder_tb_top.sv */
// self-checking bench for the octal dac command decoder, RES = 16
// assumes the host model drives the bus; outputs settle within a few cycles of a stop
`timescale 1ns/10ps
module octal_dac_serial_command_decoder_tb_top;
  import ocdac_pkg::*;
  logic ref_clk, rst_n, load_strobe_n, reset_scale_select;
  ocdac_pin_t pin0, pin1, pin2;
  logic sda_o, sda_oe, scl, host_low, ref_internal, ref_powered;
  wire logic sda_line;
  logic [NUM_CH-1:0][15:0] dac_code, eo, ei;
  logic [NUM_CH-1:0] pd, epd;
  logic [6:0] dadr;
  int err_total, compares;

  // ==========================================================================
  // wired-and data line with pull-up: either party may pull it low
  assign sda_line = (host_low || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;

  ocdac_top #(.RES(16)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .load_strobe_n(load_strobe_n),
    .reset_scale_select(reset_scale_select), .addr_pin_0(pin0), .addr_pin_1(pin1),
    .addr_pin_2(pin2), .dac_code(dac_code), .chan_powered_down(pd),
    .ref_internal(ref_internal), .ref_powered(ref_powered));

  ocdac_host_model host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl),
    .sda_low(host_low));

  // 50 MHz reference clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // helpers
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic outs;
    chk(dac_code, eo);
    chk(128'(pd), 128'(epd));
  endtask

  task automatic refs(input logic [1:0] e);
    chk(128'({ref_internal, ref_powered}), 128'(e));
  endtask

  task automatic send(input logic [7:0] a, input logic [7:0] cs, input logic [15:0] d,
                      input int nb, output logic [4:0] nk);
    host.frame({a, cs, d, 8'hA5}, nb, nk);
    tk(4);
  endtask

  // full write to this device; every byte must be acknowledged
  task automatic wr(input logic [3:0] c, input logic [3:0] s, input logic [15:0] d);
    logic [4:0] nk;
    send({dadr, 1'b0}, {c, s}, d, 4, nk);
    chk(128'(nk), 128'h0);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset_zero;
    outs();
    refs(2'b11);
  endtask

  task automatic t_writes;
    wr(4'h0, 4'h2, 16'h1234);
    ei[2] = 16'h1234;
    outs();
    wr(4'h1, 4'h2, 16'hFFFF);
    eo[2] = ei[2];
    outs();
    // every channel code in turn, then all channels, then the no-op
    for (int c = 0; c < 8; c++) begin
      wr(4'h3, 4'(c), {4'(c), 12'hC5A});
      ei[c] = {4'(c), 12'hC5A};
      eo[c] = ei[c];
      outs();
    end
    wr(4'h3, 4'hF, 16'h0F0F);
    ei = {8{16'h0F0F}};
    eo = ei;
    outs();
    wr(4'hF, 4'h3, 16'h9999);
    outs();
  endtask

  task automatic t_power;
    wr(4'h4, 4'h5, 16'h0000);
    epd[5] = 1'b1;
    outs();
    wr(4'h1, 4'h5, 16'h0000);
    epd[5] = 1'b0;
    outs();
    wr(4'h0, 4'h1, 16'h4321);
    ei[1] = 16'h4321;
    wr(4'h5, 4'h0, 16'h0000);
    epd = '1;
    outs();
    refs(2'b10);
    wr(4'h2, 4'h0, 16'h5555);
    ei[0] = 16'h5555;
    eo = ei;
    epd = '0;
    outs();
    wr(4'h7, 4'h0, 16'h0000);
    refs(2'b00);
    wr(4'h6, 4'h0, 16'h0000);
    refs(2'b11);
  endtask

  task automatic t_frames;
    logic [4:0] nk;
    send({7'h11, 1'b0}, 8'h30, 16'h7777, 4, nk);
    chk(128'(nk), 128'h1E);
    send({dadr, 1'b1}, 8'h30, 16'h7777, 2, nk);
    chk(128'(nk), 128'h18);
    send({dadr, 1'b0}, 8'h30, 16'h1111, 3, nk);
    chk(128'(nk), 128'h00);
    outs();
    send({dadr, 1'b0}, 8'h31, 16'h2222, 5, nk);
    chk(128'(nk), 128'h01);
    ei[1] = 16'h2222;
    eo[1] = ei[1];
    send({7'h73, 1'b0}, 8'h33, 16'h3333, 4, nk);
    chk(128'(nk), 128'h00);
    ei[3] = 16'h3333;
    eo[3] = ei[3];
    outs();
    // move the strapped address: high, float, low selects 1100001
    pin2 <= OCDAC_PIN_HIGH;
    pin1 <= OCDAC_PIN_FLOAT;
    tk(8);
    dadr = 7'h61;
    wr(4'h3, 4'h4, 16'h4444);
    ei[4] = 16'h4444;
    eo[4] = ei[4];
    send({7'h10, 1'b0}, 8'h34, 16'h0001, 4, nk);
    chk(128'(nk), 128'h1E);
    outs();
  endtask

  task automatic t_strobe;
    wr(4'h0, 4'h6, 16'hBEEF);
    ei[6] = 16'hBEEF;
    outs();
    load_strobe_n <= 1'b0;
    tk(6);
    eo = ei;
    outs();
    wr(4'h4, 4'hF, 16'h0000);
    wr(4'h5, 4'h0, 16'h0000);
    outs();
    refs(2'b11);
    load_strobe_n <= 1'b1;
    tk(4);
  endtask

  // second reset in mid-run with the strap high
  task automatic t_midscale;
    rst_n <= 1'b0;
    reset_scale_select <= 1'b1;
    tk(8);
    rst_n <= 1'b1;
    tk(8);
    eo = {8{16'h8000}};
    epd = '0;
    outs();
    refs(2'b11);
  endtask

  // ==========================================================================
  // verdict and run end
  task automatic test_done;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    load_strobe_n = 1'b1;
    reset_scale_select = 1'b0;
    pin0 = OCDAC_PIN_LOW;
    pin1 = OCDAC_PIN_LOW;
    pin2 = OCDAC_PIN_LOW;
    dadr = 7'h10;
    err_total = 0;
    compares = 0;
    eo = '0;
    ei = '0;
    epd = '0;
    tk(8);
    rst_n <= 1'b1;
    tk(8);
    t_reset_zero();
    t_writes();
    t_power();
    t_frames();
    t_strobe();
    t_midscale();
    test_done();
  end

  // watchdog: about 30 frames of 300 cycles fit well inside 1 ms
  initial begin
    #1000000;
    err_total++;
    test_done();
  end
endmodule
